/* src/usmi_core.v */
// Mode register decode, channel routing, smart card NACK limiting and interrupt mask of the serial port
//
// Notes on behaviour
// - Parity code: even, odd, forced 0, forced 1, none for 10x, multidrop for 11x.
// - Asynchronous stop bits: 00 one, 01 one and a half, 10 two, 11 reserved.
// - Synchronous stop bits: 00 one, 10 two; 01 and 11 reserved.
// - Channel mode 00 normal; 01 echoes the receiver input onto the transmit pin.
// - Channel mode 10 feeds the transmitter output into the receiver input.
// - Channel mode 11 ties the receive pin straight to the transmit pin.
// - msb_first selects bit order for both transmit and receive characters.
// - nine_bit_char forces nine-bit characters, otherwise length from char_len_field.
// - Serial clock pin driven only with serial_clock_drive set and internal clock selected.
// - Oversampling is sixteen when oversample_select is 0, eight when 1.
// - inhibit_nack set suppresses every non-acknowledge.
// - Without limiting, each parity error gives an immediate non-acknowledge.
// - With limiting, consecutive parity errors are counted, each acknowledged negatively.
// - Count at max_repeat_count stops further non-acknowledges and sets repeat_limit_flag.
// - max_repeat_count is the repetition limit in smart card T=0 mode.
// - ir_rx_filter takes one sample per sample_tick and votes two of the last three.
// - Enable, disable and mask share bits 0-13 and 16-19; others reserved.
// - Writing 1 to irq_enable_set enables that source; 0 does nothing.
// - Writing 1 to irq_enable_clear disables that source; 0 does nothing.
// - sync_select 0 gives asynchronous, 1 synchronous operation.
// - clear_repeat_cmd clears repeat_limit_flag, only while smart card mode is on.
`include "usmi_regs.vh"
`timescale 1ns/100ps

module usmi_core #(
   parameter ADDR_W = 8
) (
   input  wire              clk,
   input  wire              nrst,
   input  wire              hsel,
   input  wire [ADDR_W-1:0] haddr,
   input  wire [1:0]        htrans,
   input  wire              hwrite,
   input  wire [2:0]        hsize,
   input  wire [31:0]       hwdata,
   input  wire              hready,
   output reg               hreadyout,
   output reg               hresp,
   output reg  [31:0]       hrdata,
   input  wire              rxd_pin,
   output reg               txd_pin,
   input  wire              tx_core_bit,
   output reg               rx_core_bit,
   input  wire              sample_tick,
   input  wire              baud_clk_level,
   output reg               sck_out,
   output reg               sck_oe,
   input  wire [8:0]        tx_char,
   output reg  [8:0]        tx_shift_word,
   input  wire [8:0]        rx_shift_word,
   output reg  [8:0]        rx_char,
   input  wire              rx_char_done,
   input  wire              rx_par_err,
   output reg               nack_pulse,
   output reg               repeat_limit_flag,
   input  wire [19:0]       status_in,
   output reg               irq,
   output reg               sync_mode,
   output reg  [2:0]        parity_kind,
   output reg  [2:0]        stop_half_bits,
   output reg               stop_reserved,
   output reg  [3:0]        char_bits,
   output reg  [4:0]        oversample
);

   // ----------------------------------------------------------------
   // Parity kinds and helpers
   // ----------------------------------------------------------------
   localparam [2:0] PK_EVEN  = 3'h0;
   localparam [2:0] PK_ODD   = 3'h1;
   localparam [2:0] PK_SPACE = 3'h2;
   localparam [2:0] PK_MARK  = 3'h3;
   localparam [2:0] PK_NONE  = 3'h4;
   localparam [2:0] PK_MDROP = 3'h5;

   // Places the first bit to shift at bit 0, honouring length and order
   function [8:0] order_char;
      input [8:0] data;
      input [3:0] len;
      input       msb_first;
      reg   [8:0] rev;
      integer     i;
      begin
         rev = 9'h000;
         for (i = 0; i < 9; i = i + 1) begin
            rev[i] = data[8 - i];
         end
         if (msb_first) begin
            order_char = rev >> (4'h9 - len);
         end else begin
            order_char = data;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   reg  [31:0]       mode_r;
   reg  [19:0]       mask_r;
   reg               wr_pend_r;
   reg               rd_pend_r;
   reg  [ADDR_W-1:0] addr_r;
   reg  [31:0]       rd_mux;
   wire              take    = hsel & htrans[1] & hready & hreadyout;
   wire              wr_ctrl = wr_pend_r && (addr_r[7:0] == `USMI_OFS_CTRL);
   wire [19:0]       flags;

   always @* begin
      case (addr_r[7:0])
         `USMI_OFS_MODE:     rd_mux = mode_r;
         `USMI_OFS_IEN_VIEW: rd_mux = {12'h000, mask_r};
         `USMI_OFS_STATUS:   rd_mux = {12'h000, flags};
         default:            rd_mux = 32'h00000000;
      endcase
   end

   // Reads take one wait state so that a write just before is visible
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h00000000;
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r    <= {ADDR_W{1'b0}};
      end else begin
         hresp     <= 1'b0;
         wr_pend_r <= take & hwrite;
         if (take) begin
            addr_r <= haddr;
         end
         if (take & ~hwrite) begin
            rd_pend_r <= 1'b1;
            hreadyout <= 1'b0;
         end else if (rd_pend_r) begin
            rd_pend_r <= 1'b0;
            hrdata    <= rd_mux;
            hreadyout <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Mode and mask registers
   // ----------------------------------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mode_r <= `USMI_MODE_RESET;
         mask_r <= `USMI_MASK_RESET;
      end else if (wr_pend_r) begin
         if (addr_r[7:0] == `USMI_OFS_MODE) begin
            mode_r <= hwdata;
         end
         if (addr_r[7:0] == `USMI_OFS_IEN_SET) begin
            mask_r <= mask_r | (hwdata[19:0] & `USMI_MASK_VALID);
         end
         if (addr_r[7:0] == `USMI_OFS_IEN_CLR) begin
            mask_r <= mask_r & ~(hwdata[19:0] & `USMI_MASK_VALID);
         end
      end
   end

   wire [3:0] f_mode   = mode_r[`USMI_F_MODE_LSB +: 4];
   wire [1:0] f_clksel = mode_r[`USMI_F_CLKSEL_LSB +: 2];
   wire [1:0] f_char_len_field   = mode_r[`USMI_F_CHAR_LEN_FIELD_LSB +: 2];
   wire       f_sync   = mode_r[`USMI_F_SYNC];
   wire [2:0] f_par    = mode_r[`USMI_F_PAR_LSB +: 3];
   wire [1:0] f_stop_bit_count = mode_r[`USMI_F_STOP_BIT_COUNT_LSB +: 2];
   wire [1:0] f_channel_mode = mode_r[`USMI_F_CHANNEL_MODE_LSB +: 2];
   wire       f_msb_first   = mode_r[`USMI_F_MSB_FIRST];
   wire       f_nine_bit_char  = mode_r[`USMI_F_NINE_BIT_CHAR];
   wire       f_serial_clock_drive   = mode_r[`USMI_F_SERIAL_CLOCK_DRIVE];
   wire       f_over   = mode_r[`USMI_F_OVER];
   wire       f_inhibit_nack  = mode_r[`USMI_F_INHIBIT_NACK];
   wire       f_limit_successive_nack = mode_r[`USMI_F_LIMIT_SUCCESSIVE_NACK];
   wire [2:0] f_maxit  = mode_r[`USMI_F_MAXIT_LSB +: 3];
   wire       f_filter = mode_r[`USMI_F_FILTER];
   wire       iso_t0   = (f_mode == `USMI_MODE_ISO_T0);
   wire [3:0] len_now  = f_nine_bit_char ? 4'h9 : ({2'b00, f_char_len_field} + 4'h5);

   // ----------------------------------------------------------------
   // Framing decode
   // ----------------------------------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync_mode      <= 1'b0;
         parity_kind    <= PK_EVEN;
         stop_half_bits <= 3'h2;
         stop_reserved  <= 1'b0;
         char_bits      <= 4'h5;
         oversample     <= `USMI_OVS_16;
         sck_out        <= 1'b0;
         sck_oe         <= 1'b0;
      end else begin
         sync_mode <= f_sync;
         case (f_par)
            3'h0:    parity_kind <= PK_EVEN;
            3'h1:    parity_kind <= PK_ODD;
            3'h2:    parity_kind <= PK_SPACE;
            3'h3:    parity_kind <= PK_MARK;
            3'h4,
            3'h5:    parity_kind <= PK_NONE;
            default: parity_kind <= PK_MDROP;
         endcase
         case (f_stop_bit_count)
            2'h0: begin
               stop_half_bits <= 3'h2;
               stop_reserved  <= 1'b0;
            end
            2'h1: begin
               stop_half_bits <= f_sync ? 3'h2 : 3'h3;
               stop_reserved  <= f_sync;
            end
            2'h2: begin
               stop_half_bits <= 3'h4;
               stop_reserved  <= 1'b0;
            end
            default: begin
               stop_half_bits <= 3'h2;
               stop_reserved  <= 1'b1;
            end
         endcase
         char_bits  <= len_now;
         oversample <= f_over ? `USMI_OVS_8 : `USMI_OVS_16;
         sck_oe     <= f_serial_clock_drive && (f_clksel != `USMI_CLK_EXTERNAL);
         sck_out    <= baud_clk_level;
      end
   end

   // ----------------------------------------------------------------
   // Bit order of characters
   // ----------------------------------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_shift_word <= 9'h000;
         rx_char       <= 9'h000;
      end else begin
         tx_shift_word <= order_char(tx_char, len_now, f_msb_first);
         rx_char       <= order_char(rx_shift_word, len_now, f_msb_first);
      end
   end

   // ----------------------------------------------------------------
   // Receive synchroniser, infrared filter and channel routing
   // ----------------------------------------------------------------
   reg       rx_s1_r;
   reg       rx_s2_r;
   reg [2:0] filt_r;
   wire      vote    = (filt_r[0] & filt_r[1]) | (filt_r[1] & filt_r[2]) | (filt_r[0] & filt_r[2]);
   wire      rx_line = f_filter ? vote : rx_s2_r;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_s1_r     <= 1'b1;
         rx_s2_r     <= 1'b1;
         filt_r      <= 3'h7;
         txd_pin     <= 1'b1;
         rx_core_bit <= 1'b1;
      end else begin
         rx_s1_r <= rxd_pin;
         rx_s2_r <= rx_s1_r;
         if (sample_tick) begin
            filt_r <= {filt_r[1:0], rx_s2_r};
         end
         case (f_channel_mode)
            2'h0: begin
               txd_pin     <= tx_core_bit;
               rx_core_bit <= rx_line;
            end
            2'h1: begin
               txd_pin     <= rx_line;
               rx_core_bit <= rx_line;
            end
            2'h2: begin
               txd_pin     <= 1'b1;
               rx_core_bit <= tx_core_bit;
            end
            default: begin
               txd_pin     <= rx_s2_r;
               rx_core_bit <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Smart card non-acknowledge and repetition limit
   // ----------------------------------------------------------------
   reg  [2:0] err_cnt_r;
   wire       clr_rep = wr_ctrl && hwdata[`USMI_CR_CLR_REPEAT] && iso_t0;
   wire       got_err = iso_t0 && rx_char_done && rx_par_err;
   wire       at_lim  = f_limit_successive_nack && (err_cnt_r == f_maxit);
   wire       hit_lim = got_err && f_limit_successive_nack && ((err_cnt_r + 3'h1) == f_maxit || at_lim);

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         err_cnt_r         <= 3'h0;
         nack_pulse        <= 1'b0;
         repeat_limit_flag <= 1'b0;
      end else begin
         nack_pulse <= got_err && !f_inhibit_nack && !at_lim;
         if (clr_rep) begin
            err_cnt_r <= 3'h0;
         end else if (iso_t0 && rx_char_done && !rx_par_err) begin
            err_cnt_r <= 3'h0;
         end else if (got_err && f_limit_successive_nack && !at_lim) begin
            err_cnt_r <= err_cnt_r + 3'h1;
         end
         // A limit reached in the clearing cycle still wins
         if (hit_lim) begin
            repeat_limit_flag <= 1'b1;
         end else if (clr_rep) begin
            repeat_limit_flag <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt output
   // ----------------------------------------------------------------
   assign flags = {status_in[19:11], repeat_limit_flag, status_in[9:0]} & `USMI_MASK_VALID;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flags & mask_r);
      end
   end

   // Unused bus qualifier
   wire unused_ok = &{1'b0, hsize};

endmodule

/* src/usmi_regs.vh */
// Register offsets, field positions and reset values of the serial port mode and mask block
`ifndef USMI_REGS_VH
`define USMI_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define USMI_OFS_CTRL      8'h00
`define USMI_OFS_MODE      8'h04
`define USMI_OFS_IEN_SET   8'h08
`define USMI_OFS_IEN_CLR   8'h0C
`define USMI_OFS_IEN_VIEW  8'h10
`define USMI_OFS_STATUS    8'h14

// ----------------------------------------------------------------
// Fields of line_mode_config
// ----------------------------------------------------------------
`define USMI_F_MODE_LSB    0
`define USMI_F_CLKSEL_LSB  4
`define USMI_F_CHAR_LEN_FIELD_LSB    6
`define USMI_F_SYNC        8
`define USMI_F_PAR_LSB     9
`define USMI_F_STOP_BIT_COUNT_LSB  12
`define USMI_F_CHANNEL_MODE_LSB  14
`define USMI_F_MSB_FIRST        16
`define USMI_F_NINE_BIT_CHAR       17
`define USMI_F_SERIAL_CLOCK_DRIVE        18
`define USMI_F_OVER        19
`define USMI_F_INHIBIT_NACK       20
`define USMI_F_LIMIT_SUCCESSIVE_NACK      21
`define USMI_F_MAXIT_LSB   24
`define USMI_F_FILTER      28

// ----------------------------------------------------------------
// Control command bits and status bits used here
// ----------------------------------------------------------------
`define USMI_CR_CLR_REPEAT 13
`define USMI_ST_ITERATION  10

// ----------------------------------------------------------------
// Reset and layout values
// ----------------------------------------------------------------
`define USMI_MODE_RESET    32'h00000000
`define USMI_MASK_RESET    20'h00000
`define USMI_MASK_VALID    20'hF3FFF
`define USMI_MODE_ISO_T0   4'h4
`define USMI_CLK_EXTERNAL  2'h3
`define USMI_OVS_16        5'h10
`define USMI_OVS_8         5'h08

`endif

/* test/usart_mode_and_irq_mask_tb.sv */
// Self-checking testbench of the serial port mode and mask block
`timescale 1ns/100ps
`include "usmi_regs.vh"
module usart_mode_and_irq_mask_tb;
   reg         clk = 1'h0, nrst = 1'h0, hsel = 1'h0, hwrite = 1'h0, line_lvl = 1'h1, tx_core_bit = 1'h1;
   reg         rx_char_done = 1'h0, rx_par_err = 1'h0, n;
   reg  [7:0]  haddr = 8'h00;
   reg  [1:0]  htrans = 2'h0;
   reg  [31:0] hwdata = 32'h0, rd;
   reg  [8:0]  tx_char = 9'h000, rx_shift_word = 9'h000;
   reg  [19:0] status_in = 20'h00000;
   wire        hreadyout, hresp, txd_pin, rx_core_bit, rxd_pin, sample_tick, baud_clk_level, sck_out, sck_oe;
   wire        nack_pulse, repeat_limit_flag, irq, sync_mode, stop_reserved;
   wire [31:0] hrdata;
   wire [8:0]  tx_shift_word, rx_char;
   wire [2:0]  parity_kind, stop_half_bits;
   wire [3:0]  char_bits;
   wire [4:0]  oversample;
   integer     miscompares = 0, comparisons = 0, cyc = 0, i, m, k;
   usmi_core usmi_core_i (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .rxd_pin(rxd_pin), .txd_pin(txd_pin), .tx_core_bit(tx_core_bit), .rx_core_bit(rx_core_bit),
      .sample_tick(sample_tick), .baud_clk_level(baud_clk_level), .sck_out(sck_out), .sck_oe(sck_oe),
      .tx_char(tx_char), .tx_shift_word(tx_shift_word), .rx_shift_word(rx_shift_word), .rx_char(rx_char),
      .rx_char_done(rx_char_done), .rx_par_err(rx_par_err), .nack_pulse(nack_pulse),
      .repeat_limit_flag(repeat_limit_flag), .status_in(status_in), .irq(irq), .sync_mode(sync_mode),
      .parity_kind(parity_kind), .stop_half_bits(stop_half_bits), .stop_reserved(stop_reserved),
      .char_bits(char_bits), .oversample(oversample));
   usmi_line_peer usmi_line_peer_i (.clk(clk), .nrst(nrst), .line_lvl(line_lvl), .rxd_pin(rxd_pin),
      .sample_tick(sample_tick), .baud_clk_level(baud_clk_level));
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         miscompares = miscompares + 1;
         print_verdict;
      end
   end
   // ------------------------------------------------
   // Shared tasks
   // ------------------------------------------------
   task print_verdict;
      begin
         $display("comparisons %0d miscompares %0d", comparisons, miscompares);
         if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] s, input [31:0] e, input [8*16:1] msg);
      begin
         comparisons = comparisons + 1;
         if (s !== e) begin
            miscompares = miscompares + 1;
            $display("MISMATCH at %0t: %0s seen %h expected %h", $time, msg, s, e);
         end
      end
   endtask
   task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
      begin
         hsel   <= 1'h1;
         haddr  <= a;
         htrans <= 2'h2;
         hwrite <= w;
         @(posedge clk);
         while (hreadyout !== 1'h1) @(posedge clk);
         htrans <= 2'h0;
         hwdata <= d;
         @(posedge clk);
         while (hreadyout !== 1'h1) @(posedge clk);
         q = hrdata;
      end
   endtask
   task wmode(input [31:0] d);
      begin
         xfer(1'h1, `USMI_OFS_MODE, d, rd);
         repeat (3) @(posedge clk);
      end
   endtask
   task perr(input en, input ef);
      begin
         rx_char_done <= 1'h1;
         rx_par_err   <= 1'h1;
         @(posedge clk);
         rx_char_done <= 1'h0;
         rx_par_err   <= 1'h0;
         n = 1'h0;
         repeat (3) begin
            @(posedge clk);
            n = n | nack_pulse;
         end
         chk(n, en, "nack");
         chk(repeat_limit_flag, ef, "limit flag");
      end
   endtask
   task glitch(input ef);
      begin
         line_lvl <= 1'h0;
         repeat (4) @(posedge clk);
         line_lvl <= 1'h1;
         n = 1'h1;
         repeat (12) begin
            @(posedge clk);
            n = n & rx_core_bit;
         end
         chk(n, ef, "ir glitch");
      end
   endtask
   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task t_regs;
      begin
         xfer(1'h0, `USMI_OFS_IEN_VIEW, 32'h0, rd);
         chk(rd, 32'h0, "mask reset");
         chk({stop_half_bits, char_bits, oversample}, {3'h2, 4'h5, 5'h10}, "decode reset");
         xfer(1'h1, `USMI_OFS_IEN_SET, 32'hFFFFFFFF, rd);
         xfer(1'h0, `USMI_OFS_IEN_VIEW, 32'h0, rd);
         chk(rd, 32'h000F3FFF, "mask set");
         xfer(1'h1, `USMI_OFS_IEN_CLR, 32'h0000000F, rd);
         xfer(1'h1, `USMI_OFS_IEN_SET, 32'h0, rd);
         xfer(1'h1, `USMI_OFS_IEN_CLR, 32'h0, rd);
         xfer(1'h1, `USMI_OFS_IEN_VIEW, 32'h0, rd);
         xfer(1'h0, `USMI_OFS_IEN_VIEW, 32'h0, rd);
         chk(rd, 32'h000F3FF0, "mask clear");
         xfer(1'h0, 8'h40, 32'h0, rd);
         chk(rd, 32'h0, "unmapped");
         xfer(1'h1, `USMI_OFS_MODE, 32'h1735A6C5, rd);
         xfer(1'h0, `USMI_OFS_MODE, 32'h0, rd);
         chk(rd, 32'h1735A6C5, "mode readback");
         xfer(1'h1, `USMI_OFS_IEN_CLR, 32'hFFFFFFFF, rd);
         $display("test regs done");
      end
   endtask
   task t_irq;
      begin
         status_in <= 20'h00010;
         xfer(1'h1, `USMI_OFS_IEN_SET, 32'h00000010, rd);
         repeat (3) @(posedge clk);
         chk(irq, 1'h1, "irq on");
         xfer(1'h1, `USMI_OFS_IEN_CLR, 32'h00000010, rd);
         xfer(1'h1, `USMI_OFS_IEN_SET, 32'h00000001, rd);
         repeat (3) @(posedge clk);
         chk(irq, 1'h0, "irq masked");
         status_in <= 20'h00000;
         xfer(1'h1, `USMI_OFS_IEN_CLR, 32'hFFFFFFFF, rd);
         $display("test irq done");
      end
   endtask
   task t_mode;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            wmode(i << `USMI_F_PAR_LSB);
            chk(parity_kind, (i < 4) ? i : (i < 6) ? 4 : 5, "parity");
            wmode(((i >> 2) << `USMI_F_SYNC) | ((i % 4) << `USMI_F_STOP_BIT_COUNT_LSB));
            n = (i % 4 == 3) || (i == 5);
            chk({stop_reserved, stop_half_bits}, {n, n ? 3'h2 : 3'h2 + {1'b0, i[1:0]}}, "stop bits");
            chk(sync_mode, i >> 2, "sync select");
         end
         for (i = 0; i < 5; i = i + 1) begin
            wmode((i < 4) ? (i << `USMI_F_CHAR_LEN_FIELD_LSB) : (1 << `USMI_F_NINE_BIT_CHAR));
            chk(char_bits, 5 + i, "char length");
         end
         wmode(1 << `USMI_F_OVER);
         chk(oversample, `USMI_OVS_8, "oversample");
         $display("test mode done");
      end
   endtask
   task t_order_sck;
      begin
         tx_char       <= 9'h001;
         rx_shift_word <= 9'h003;
         wmode((3 << `USMI_F_CHAR_LEN_FIELD_LSB) | (1 << `USMI_F_MSB_FIRST) | (1 << `USMI_F_SERIAL_CLOCK_DRIVE));
         chk({tx_shift_word, rx_char}, {9'h080, 9'h0C0}, "msb first");
         chk(sck_oe, 1'h1, "sck driven");
         wmode((3 << `USMI_F_CHAR_LEN_FIELD_LSB) | (1 << `USMI_F_SERIAL_CLOCK_DRIVE) | (3 << `USMI_F_CLKSEL_LSB));
         chk({tx_shift_word, rx_char}, {9'h001, 9'h003}, "lsb first");
         chk(sck_oe, 1'h0, "sck external");
         $display("test order done");
      end
   endtask
   task t_chan;
      begin
         for (m = 0; m < 4; m = m + 1)
            for (k = 0; k < 2; k = k + 1) begin
               xfer(1'h1, `USMI_OFS_MODE, m << `USMI_F_CHANNEL_MODE_LSB, rd);
               tx_core_bit <= k[0];
               line_lvl    <= ~k[0];
               repeat (6) @(posedge clk);
               chk(txd_pin, (m == 0) ? k[0] : (m == 2) ? 1'h1 : !k[0], "txd route");
               chk(rx_core_bit, (m < 2) ? !k[0] : (m == 2) ? k[0] : 1'h1, "rx route");
            end
         line_lvl <= 1'h1;
         wmode(1 << `USMI_F_FILTER);
         repeat (20) @(posedge clk);
         glitch(1'h1);
         line_lvl <= 1'h0;
         repeat (30) @(posedge clk);
         chk(rx_core_bit, 1'h0, "filtered low");
         line_lvl <= 1'h1;
         wmode(32'h0);
         repeat (30) @(posedge clk);
         glitch(1'h0);
         $display("test chan done");
      end
   endtask
   task t_nack;
      begin
         wmode(`USMI_MODE_ISO_T0);
         perr(1'h1, 1'h0);
         wmode(`USMI_MODE_ISO_T0 | (1 << `USMI_F_INHIBIT_NACK));
         perr(1'h0, 1'h0);
         wmode(`USMI_MODE_ISO_T0 | (1 << `USMI_F_LIMIT_SUCCESSIVE_NACK) | (2 << `USMI_F_MAXIT_LSB));
         perr(1'h1, 1'h0);
         perr(1'h1, 1'h1);
         perr(1'h0, 1'h1);
         wmode(32'h0);
         xfer(1'h1, `USMI_OFS_CTRL, 1 << `USMI_CR_CLR_REPEAT, rd);
         repeat (3) @(posedge clk);
         chk(repeat_limit_flag, 1'h1, "clear ignored");
         wmode(`USMI_MODE_ISO_T0);
         xfer(1'h1, `USMI_OFS_CTRL, 1 << `USMI_CR_CLR_REPEAT, rd);
         repeat (3) @(posedge clk);
         chk(repeat_limit_flag, 1'h0, "clear done");
         $display("test nack done");
      end
   endtask
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      t_regs;
      t_irq;
      t_mode;
      t_order_sck;
      t_chan;
      t_nack;
      print_verdict;
   end
endmodule

/* test/usmi_core_props.sv */
// Concurrent assertions on the ports of the serial port mode and mask block
`timescale 1ns/100ps
`include "usmi_regs.vh"
module usmi_core_props (
   input wire        clk,
   input wire        nrst,
   input wire        hsel,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire        hreadyout,
   input wire        hresp,
   input wire [31:0] hrdata,
   input wire        baud_clk_level,
   input wire        sck_out,
   input wire        sck_oe,
   input wire        rx_char_done,
   input wire        rx_par_err,
   input wire        nack_pulse,
   input wire        repeat_limit_flag,
   input wire [19:0] status_in,
   input wire        irq,
   input wire [4:0]  oversample
);
   // ------------------------------------------------
   // Bus, event and decode properties
   // ------------------------------------------------
   wire take = hsel & htrans[1] & hready & hreadyout;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   property p_okay;
      hresp == 1'h0;
   endproperty
   a_okay: assert property (p_okay) else $error("bus response not okay");
   property p_rd_wait;
      take && !hwrite |=> !hreadyout ##1 hreadyout;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   property p_wr_nowait;
      take && hwrite |=> hreadyout;
   endproperty
   a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
   property p_rd_hold;
      hreadyout && $past(hreadyout) |-> $stable(hrdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data changed unasked");
   property p_nack_cause;
      nack_pulse |-> $past(rx_char_done & rx_par_err);
   endproperty
   a_nack_cause: assert property (p_nack_cause) else $error("nack without parity error");
   property p_flag_cause;
      $rose(repeat_limit_flag) |-> $past(rx_char_done & rx_par_err);
   endproperty
   a_flag_cause: assert property (p_flag_cause) else $error("limit flag without error");
   property p_irq_quiet;
      (status_in == 20'h00000 && !repeat_limit_flag) [*3] |-> !irq;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt with no flag");
   property p_sck_copy;
      sck_oe |-> sck_out == $past(baud_clk_level);
   endproperty
   a_sck_copy: assert property (p_sck_copy) else $error("serial clock not followed");
   property p_ovs;
      oversample == `USMI_OVS_16 || oversample == `USMI_OVS_8;
   endproperty
   a_ovs: assert property (p_ovs) else $error("oversampling value illegal");
   c_read: cover property (take && !hwrite);
   c_nack: cover property (nack_pulse);
   c_flag: cover property ($rose(repeat_limit_flag));
endmodule
bind usmi_core usmi_core_props usmi_core_props_i (.clk(clk), .nrst(nrst), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .baud_clk_level(baud_clk_level), .sck_out(sck_out), .sck_oe(sck_oe), .rx_char_done(rx_char_done),
   .rx_par_err(rx_par_err), .nack_pulse(nack_pulse), .repeat_limit_flag(repeat_limit_flag),
   .status_in(status_in), .irq(irq), .oversample(oversample));

/* test/usmi_line_peer.sv */
// Serial line peer: receive pin level, sample tick and serial clock level
`timescale 1ns/100ps
module usmi_line_peer (
   input  wire clk,
   input  wire nrst,
   input  wire line_lvl,
   output reg  rxd_pin,
   output reg  sample_tick,
   output reg  baud_clk_level
);
   reg [3:0] div_r;
   // Tick every fourth cycle, clock level toggles every eight
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_r          <= 4'h0;
         rxd_pin        <= 1'h1;
         sample_tick    <= 1'h0;
         baud_clk_level <= 1'h0;
      end else begin
         div_r          <= div_r + 4'h1;
         rxd_pin        <= line_lvl;
         sample_tick    <= (div_r[1:0] == 2'h3);
         baud_clk_level <= div_r[3];
      end
   end
endmodule
